// >>> bench/test_dual_timer_pair_control.sv
// self-checking bench for the timer pair control block
`timescale 1ns/1ns
`default_nettype none
module test_dual_timer_pair_control;
  import dtpc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr;
  logic pin = 1'b1, lfClk = 1'b0, slow = 1'b0, dvSel = 1'b0, stopEnt = 1'b0;
  dtpc_opmode_t u0Mode = OPM_TIMER_A;
  logic u0Pwm = 1'b0, u1Pwm = 1'b0, u0Ppg = 1'b0, u1Ppg = 1'b0;
  logic p0w, p0p, p1w, p1p, adv0, adv1, dbl, casc;
  dtpc_opmode_t opm;
  logic [7:0] pwr;
  int miscompares = 0, nChecks = 0, cyc = 0, advCnt = 0, adv0Cnt = 0;
  dtpc_top dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit1CountInputPin(pin), .lowFreqClock(lfClk), .slowMode(slow),
    .dividerSourceSelect(dvSel), .stopEntry(stopEnt), .unit0Tick(1'b0),
    .unit0Mode(u0Mode), .unit0OutInit(1'b1), .unit0PwmWave(u0Pwm),
    .unit0PpgWave(u0Ppg), .unit1PwmWave(u1Pwm), .unit1PpgWave(u1Ppg),
    .unit0PulseWidthPin(p0w), .unit0PatternPin(p0p),
    .unit1PulseWidthPin(p1w), .unit1PatternPin(p1p),
    .unit0Advance(adv0), .unit1Advance(adv1), .doubleBufferEnable(dbl),
    .operatingModeSelect(opm), .cascadeMode(casc), .timerPowerEnable(pwr));
  // 50 MHz core clock; low-frequency clock of 17 core cycles, offset so
  // its edges never meet a core edge and the synchroniser sees no race
  always #10 core_clk = ~core_clk;
  initial begin
    #5;
    forever #170 lfClk = ~lfClk;
  end
  // count advance pulses on the falling edge, where they are settled and
  // never race the scenario tasks; hang guard well above the whole run
  always @(negedge core_clk) begin
    cyc++;
    if (adv1 === 1'b1) advCnt++;
    if (adv0 === 1'b1) adv0Cnt++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, {24'h0, d}, r, e);
    // the write landed on apb's last edge; let outputs settle before any check
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // reset values, power bit, unmapped place
  task automatic t_reset_regs();
    logic [31:0] r;
    logic e;
    rdchk(IDX_TIMER1_MODE, {24'h0, TIMER1_MODE_RST});
    rdchk(IDX_PAIR_CONTROL, 32'h0);
    rdchk(IDX_POWER_ENABLE, 32'h0);
    wr(IDX_POWER_ENABLE, 8'h10);
    rdchk(IDX_POWER_ENABLE, 32'h10);
    chk({24'h0, pwr}, 32'h10);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
  endtask
  // mode fields, then locks while running
  task automatic t_locks();
    wr(IDX_TIMER1_MODE, 8'h52);
    chk({31'h0, dbl}, 32'h1);
    chk({30'h0, opm}, 32'h2);
    wr(IDX_PAIR_CONTROL, 8'hfe);
    rdchk(IDX_PAIR_CONTROL, 32'h0e);
    chk({31'h0, casc}, 32'h1);
    wr(IDX_TIMER1_MODE, 8'h00);
    rdchk(IDX_TIMER1_MODE, 32'h52);
    wr(IDX_PAIR_CONTROL, 8'h02);
    rdchk(IDX_PAIR_CONTROL, 32'h0e);
    @(posedge core_clk);
    stopEnt <= 1'b1;
    @(posedge core_clk);
    stopEnt <= 1'b0;
    rdchk(IDX_PAIR_CONTROL, 32'h0c);
    rdchk(IDX_COUNT_VALUE, 32'h0);
    wr(IDX_PAIR_CONTROL, 8'h00);
    rdchk(IDX_PAIR_CONTROL, 32'h0);
  endtask
  // count unit 1 advances over a window of win cycles for one clock code
  task automatic tick_win(input logic [2:0] code, input logic s,
      input int win, input int exp);
    int c0;
    wr(IDX_PAIR_CONTROL, 8'h00);
    slow <= s;
    wr(IDX_TIMER1_MODE, {2'b00, code, 3'b000});
    wr(IDX_PAIR_CONTROL, 8'h02);
    wait_clk(8);
    c0 = advCnt;
    wait_clk(win);
    chk(advCnt - c0, exp);
  endtask
  task automatic t_ticks();
    int c0;
    tick_win(3'h6, 1'b0, 64, 32);
    tick_win(3'h5, 1'b0, 64, 16);
    tick_win(3'h7, 1'b0, 64, 64);
    // cascade: low byte runs on unit 1's run bit and undivided clock
    wr(IDX_PAIR_CONTROL, 8'h00);
    wr(IDX_PAIR_CONTROL, 8'h06);
    wait_clk(8);
    c0 = adv0Cnt;
    wait_clk(64);
    chk(adv0Cnt - c0, 64);
    // 272 cycles hold exactly 16 low-frequency rising edges
    dvSel <= 1'b1;
    tick_win(3'h1, 1'b0, 272, 2);
    dvSel <= 1'b0;
    tick_win(3'h2, 1'b1, 64, 0);
    tick_win(3'h7, 1'b1, 272, 4);
    slow <= 1'b0;
    wr(IDX_POWER_ENABLE, 8'h00);
    wait_clk(8);
    c0 = advCnt;
    wait_clk(64);
    chk(advCnt - c0, 0);
    wr(IDX_POWER_ENABLE, 8'h10);
  endtask
  // external pin: one advance per falling edge
  task automatic t_ext();
    int c0;
    wr(IDX_PAIR_CONTROL, 8'h00);
    wr(IDX_TIMER1_MODE, 8'h3c);
    wr(IDX_PAIR_CONTROL, 8'h02);
    wait_clk(8);
    c0 = advCnt;
    repeat (5) begin
      pin <= 1'b0;
      wait_clk(4);
      pin <= 1'b1;
      wait_clk(4);
    end
    wait_clk(8);
    chk(advCnt - c0, 5);
  endtask
  // combined outputs land on unit 1 pins; unit 0 pins held high
  task automatic t_combine();
    wr(IDX_PAIR_CONTROL, 8'h00);
    u0Mode <= OPM_PWM;
    wr(IDX_TIMER1_MODE, 8'h3a);
    wr(IDX_PAIR_CONTROL, 8'h0b);
    u0Pwm <= 1'b1;
    u1Pwm <= 1'b0;
    wait_clk(4);
    chk({31'h0, p1w}, 32'h0);
    chk({31'h0, p0w}, 32'h1);
    chk({30'h0, p1p, p0p}, 32'h3);
    u1Pwm <= 1'b1;
    wait_clk(4);
    chk({31'h0, p1w}, 32'h1);
    // first write only stops; second clears combine; third runs both
    wr(IDX_PAIR_CONTROL, 8'h00);
    wr(IDX_PAIR_CONTROL, 8'h00);
    wr(IDX_PAIR_CONTROL, 8'h03);
    u0Pwm <= 1'b0;
    u1Pwm <= 1'b1;
    wait_clk(4);
    chk({30'h0, p1w, p0w}, 32'h2);
  endtask
  initial begin
    wait_clk(10);
    nrst <= 1'b1;
    t_reset_regs();
    t_locks();
    t_ticks();
    t_ext();
    t_combine();
    stop_test();
  end
endmodule
`default_nettype wire

// >>> core/dtpc_clk_sel.sv
// source clock selection: prescalers, low-frequency ticks, external edges
`timescale 1ns/1ns
`default_nettype none
module dtpc_clk_sel
  import dtpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic powerEn,
  input wire logic [2:0] srcSel,
  input wire logic extSel,
  input wire logic slowMode,
  input wire logic dividerSourceSelect,
  input wire logic countPin,
  input wire logic lowFreqClock,
  output logic tick
);

  logic [GEAR_DIV_W-1:0] divCnt_ff;
  logic [LF_DIV_W-1:0] lfCnt_ff;
  logic [2:0] pinSync_ff;
  logic [2:0] lfSync_ff;
  logic tick_ff;
  logic nxt_tick;
  logic pinFall;
  logic lfRise;

  // true when the low exp bits of cnt are all ones
  function automatic logic divHit(input logic [GEAR_DIV_W-1:0] cnt,
                                  input logic [3:0] exp);
    logic [GEAR_DIV_W-1:0] m;
    m = GEAR_DIV_W'((12'h001 << exp) - 12'h001);
    return &(cnt | ~m);
  endfunction

  // two-flop synchronisers; the third stage only feeds edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinSync_ff <= 3'h7;
      lfSync_ff <= 3'h0;
    end else begin
      pinSync_ff <= {pinSync_ff[1:0], countPin};
      lfSync_ff <= {lfSync_ff[1:0], lowFreqClock};
    end
  end
  assign pinFall = pinSync_ff[2] & ~pinSync_ff[1];
  assign lfRise = ~lfSync_ff[2] & lfSync_ff[1];

  // prescalers stand still while the pair is unpowered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= '0;
      lfCnt_ff <= '0;
    end else if (powerEn) begin
      divCnt_ff <= divCnt_ff + 1'b1;
      if (lfRise) begin
        lfCnt_ff <= lfCnt_ff + 1'b1;
      end
    end
  end

  // tick selection: external edge, slow state, or normal state table
  always_comb begin
    logic [GEAR_DIV_W-1:0] lfExt;
    lfExt = {{(GEAR_DIV_W-LF_DIV_W){1'b1}}, lfCnt_ff};
    nxt_tick = 1'b0;
    if (!powerEn) begin
      nxt_tick = 1'b0;
    end else if (extSel) begin
      nxt_tick = pinFall;
    end else if (slowMode) begin
      unique case (srcSel)
        SRC_SEL0: nxt_tick = lfRise & divHit(lfExt, LF_EXP_SEL0);
        SRC_SEL1: nxt_tick = lfRise & divHit(lfExt, LF_EXP_SEL1);
        SRC_SEL7: nxt_tick = lfRise & divHit(lfExt, LF_EXP_SEL7);
        default: nxt_tick = 1'b0;
      endcase
    end else if (dividerSourceSelect && srcSel == SRC_SEL0) begin
      nxt_tick = lfRise & divHit(lfExt, LF_EXP_SEL0);
    end else if (dividerSourceSelect && srcSel == SRC_SEL1) begin
      nxt_tick = lfRise & divHit(lfExt, LF_EXP_SEL1);
    end else begin
      nxt_tick = divHit(divCnt_ff, GEAR_EXP[srcSel]);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end
  assign tick = tick_ff;

  a_ext_edge: assert property (@(posedge core_clk) disable iff (!nrst)
    powerEn && extSel && pinFall |=> tick)
    else $error("external falling edge gave no tick");

  a_slow_none: assert property (@(posedge core_clk) disable iff (!nrst)
    slowMode && !extSel && srcSel != SRC_SEL0 && srcSel != SRC_SEL1 &&
    srcSel != SRC_SEL7 |=> !tick)
    else $error("slow state supplied a clock on an unusable code");

  a_gear_full: assert property (@(posedge core_clk) disable iff (!nrst)
    powerEn && !slowMode && !extSel && srcSel == SRC_SEL7 |=> tick)
    else $error("undivided gear clock did not tick");

endmodule
`default_nettype wire

// >>> core/dtpc_out_mux.sv
// pin output routing: combine, cascade and timer-mode forcing
`timescale 1ns/1ns
`default_nettype none
module dtpc_out_mux
  import dtpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic combine,
  input wire logic cascade,
  input wire dtpc_opmode_t unit0Mode,
  input wire dtpc_opmode_t unit1Mode,
  input wire logic unit0Running,
  input wire logic unit1Running,
  input wire logic unit0Init,
  input wire logic unit1Init,
  input wire logic unit0PwmWave,
  input wire logic unit0PpgWave,
  input wire logic unit1PwmWave,
  input wire logic unit1PpgWave,
  output logic [3:0] pins
);

  logic [3:0] pins_ff;
  logic u0Pwm;
  logic u0Ppg;
  logic u1Pwm;
  logic u1Ppg;

  // stopped units show the output flip-flop level; timer modes show high
  assign u0Pwm = (unit0Mode != OPM_PWM) ? 1'b1 :
                 (unit0Running ? unit0PwmWave : unit0Init);
  assign u0Ppg = (unit0Mode != OPM_PPG) ? 1'b1 :
                 (unit0Running ? unit0PpgWave : unit0Init);
  assign u1Pwm = (unit1Mode != OPM_PWM) ? 1'b1 :
                 (unit1Running ? unit1PwmWave : unit1Init);
  assign u1Ppg = (unit1Mode != OPM_PPG) ? 1'b1 :
                 (unit1Running ? unit1PpgWave : unit1Init);

  // order: {unit1 pattern, unit1 pwm, unit0 pattern, unit0 pwm}
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pins_ff <= 4'hf;
    end else if (combine) begin
      pins_ff <= {u1Ppg & u0Ppg, u1Pwm & u0Pwm, 2'b11};
    end else if (cascade) begin
      pins_ff <= {u1Ppg, u1Pwm, 2'b11};
    end else begin
      pins_ff <= {u1Ppg, u1Pwm, u0Ppg, u0Pwm};
    end
  end
  assign pins = pins_ff;

endmodule
`default_nettype wire

// >>> core/dtpc_pkg.sv
// shared constants and carrier types for the timer pair control block
package dtpc_pkg;

  // apb geometry; printed offsets are register indices, byte address = 4*idx
  localparam int APB_AW = 14;
  localparam logic [11:0] IDX_TIMER1_MODE = 12'h02b;
  localparam logic [11:0] IDX_PAIR_CONTROL = 12'h02c;
  localparam logic [11:0] IDX_COUNT_VALUE = 12'h02d;
  localparam logic [11:0] IDX_POWER_ENABLE = 12'hf74;

  // values after reset
  localparam logic [7:0] TIMER1_MODE_RST = 8'hc0;
  localparam logic [7:0] PAIR_CONTROL_RST = 8'h00;
  localparam logic [7:0] POWER_ENABLE_RST = 8'h00;

  // bit of this pair inside the shared power register
  localparam int PAIR_A_POWER_BIT = 4;

  // prescaler widths and exponents of the divided clocks
  localparam int GEAR_DIV_W = 11;
  localparam int LF_DIV_W = 4;
  localparam logic [3:0] GEAR_EXP [8] = '{4'hb, 4'ha, 4'h8, 4'h6,
                                          4'h4, 4'h2, 4'h1, 4'h0};
  localparam logic [3:0] LF_EXP_SEL0 = 4'h4;
  localparam logic [3:0] LF_EXP_SEL1 = 4'h3;
  localparam logic [3:0] LF_EXP_SEL7 = 4'h2;
  localparam logic [2:0] SRC_SEL0 = 3'h0;
  localparam logic [2:0] SRC_SEL1 = 3'h1;
  localparam logic [2:0] SRC_SEL7 = 3'h7;

  // operating modes of one unit
  typedef enum logic [1:0] {
    OPM_TIMER_A, OPM_TIMER_B, OPM_PWM, OPM_PPG
  } dtpc_opmode_t;

  // unit 1 mode register layout
  typedef struct packed {
    logic outFlipflopInit;
    logic doubleBufferEnable;
    logic [2:0] sourceClockSelect;
    logic externalSourceSelect;
    dtpc_opmode_t operatingModeSelect;
  } dtpc_mode_t;

  // shared control register layout
  typedef struct packed {
    logic [3:0] zero;
    logic outputCombine;
    logic cascade;
    logic unit1Run;
    logic unit0Run;
  } dtpc_ctrl_t;

endpackage

// >>> core/dtpc_top.sv
// timer pair control: apb registers, run control, counters, pin routing
`timescale 1ns/1ns
`default_nettype none
// Operation
// - clock code picks gear or low-frequency division
// - slow state: only three low-frequency codes
// - external bit counts pin falling edges
// - mode field picks timer, PWM, pulse
// - double buffer bit enables buffering
// - mode writes ignored while unit 1 runs
// - output flip-flop init, high in timer modes
// - power register: eight enables, reset zero
// - run starts; clearing run stops and clears
// - cascade: unit 1 run drives both
// - cascade bit joins counters to sixteen bits
// - stop state entry clears both run bits
// - control register upper nibble reads zero
// - combine bit ANDs outputs onto unit 1
// - combine: unit 0 pins stay high
// - combine and cascade locked while running
// - starting write may update combine, cascade
// - cascade uses unit 1 clock select
// - power bit off withholds timer clock
module dtpc_top
  import dtpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unit1CountInputPin,
  input wire logic lowFreqClock,
  input wire logic slowMode,
  input wire logic dividerSourceSelect,
  input wire logic stopEntry,
  input wire logic unit0Tick,
  input wire dtpc_opmode_t unit0Mode,
  input wire logic unit0OutInit,
  input wire logic unit0PwmWave,
  input wire logic unit0PpgWave,
  input wire logic unit1PwmWave,
  input wire logic unit1PpgWave,
  output logic unit0PulseWidthPin,
  output logic unit0PatternPin,
  output logic unit1PulseWidthPin,
  output logic unit1PatternPin,
  output logic unit0Advance,
  output logic unit1Advance,
  output logic doubleBufferEnable,
  output dtpc_opmode_t operatingModeSelect,
  output logic cascadeMode,
  output logic [7:0] timerPowerEnable
);

  dtpc_mode_t mode1_ff;
  dtpc_ctrl_t ctrl_ff;
  logic [7:0] power_ff;
  logic [7:0] count0_ff;
  logic [7:0] count1_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic adv0_ff;
  logic adv1_ff;
  logic [3:0] pins;
  logic clkTick1;
  logic pairEn;
  logic setup;
  logic wrAccess;
  logic runEff0;
  logic runEff1;
  logic tick0;
  logic tick1;
  logic anyRun;
  dtpc_ctrl_t wrCtrl;

  // address decode, reused by read mux, write strobes and error flag
  function automatic logic hitIdx(input logic [APB_AW-1:0] a,
                                  input logic [11:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return hitIdx(a, IDX_TIMER1_MODE) || hitIdx(a, IDX_PAIR_CONTROL) ||
           hitIdx(a, IDX_COUNT_VALUE) || hitIdx(a, IDX_POWER_ENABLE);
  endfunction

  assign pairEn = power_ff[PAIR_A_POWER_BIT];
  assign setup = psel && !penable;
  // a write lands only in the access cycle where pready is high
  assign wrAccess = psel && penable && pready_ff && pwrite &&
                    mapped(paddr);
  assign wrCtrl = dtpc_ctrl_t'(pwdata[7:0]);
  assign anyRun = ctrl_ff.unit1Run || ctrl_ff.unit0Run;

  // apb answer: data latched in setup, zero wait states in access
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped(paddr);
    end
  end

  // read mux; unmapped addresses read as zero with an error answer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= '0;
    end else if (setup) begin
      if (hitIdx(paddr, IDX_TIMER1_MODE)) begin
        prdata_ff <= {24'h000000, mode1_ff};
      end else if (hitIdx(paddr, IDX_PAIR_CONTROL)) begin
        prdata_ff <= {28'h0000000, ctrl_ff[3:0]};
      end else if (hitIdx(paddr, IDX_COUNT_VALUE)) begin
        prdata_ff <= {16'h0000, count1_ff, count0_ff};
      end else if (hitIdx(paddr, IDX_POWER_ENABLE)) begin
        prdata_ff <= {24'h000000, power_ff};
      end else begin
        prdata_ff <= '0;
      end
    end
  end

  // unit 1 mode register; frozen while unit 1 runs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode1_ff <= dtpc_mode_t'(TIMER1_MODE_RST);
    end else if (wrAccess && hitIdx(paddr, IDX_TIMER1_MODE) &&
                 !ctrl_ff.unit1Run) begin
      mode1_ff <= dtpc_mode_t'(pwdata[7:0]);
    end
  end

  // shared power register: every bit plain read/write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_ff <= POWER_ENABLE_RST;
    end else if (wrAccess && hitIdx(paddr, IDX_POWER_ENABLE)) begin
      power_ff <= pwdata[7:0];
    end
  end

  // run bits; stop-state entry beats a same-cycle write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff.unit1Run <= PAIR_CONTROL_RST[1];
      ctrl_ff.unit0Run <= PAIR_CONTROL_RST[0];
    end else if (stopEntry) begin
      ctrl_ff.unit1Run <= 1'b0;
      ctrl_ff.unit0Run <= 1'b0;
    end else if (wrAccess && hitIdx(paddr, IDX_PAIR_CONTROL)) begin
      ctrl_ff.unit1Run <= wrCtrl.unit1Run;
      ctrl_ff.unit0Run <= wrCtrl.unit0Run;
    end
  end

  // combine and cascade change only from a fully stopped pair, which also
  // lets the write that starts the pair set them in the same access
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff.outputCombine <= PAIR_CONTROL_RST[3];
      ctrl_ff.cascade <= PAIR_CONTROL_RST[2];
    end else if (wrAccess && hitIdx(paddr, IDX_PAIR_CONTROL) &&
                 !anyRun) begin
      ctrl_ff.outputCombine <= wrCtrl.outputCombine;
      ctrl_ff.cascade <= wrCtrl.cascade;
    end
  end

  // upper nibble is not storage; it always reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff.zero <= 4'h0;
    end else begin
      ctrl_ff.zero <= 4'h0;
    end
  end

  // divided clock for unit 1, which also feeds the cascaded pair
  dtpc_clk_sel u_clk_sel (
    .core_clk(core_clk),
    .nrst(nrst),
    .powerEn(pairEn),
    .srcSel(mode1_ff.sourceClockSelect),
    .extSel(mode1_ff.externalSourceSelect),
    .slowMode(slowMode),
    .dividerSourceSelect(dividerSourceSelect),
    .countPin(unit1CountInputPin),
    .lowFreqClock(lowFreqClock),
    .tick(clkTick1)
  );

  // in cascade unit 0 follows unit 1's run bit and clock
  assign runEff1 = ctrl_ff.unit1Run;
  assign runEff0 = ctrl_ff.cascade ? ctrl_ff.unit1Run :
                   ctrl_ff.unit0Run;
  assign tick1 = pairEn && runEff1 && clkTick1;
  assign tick0 = pairEn && runEff0 &&
                 (ctrl_ff.cascade ? clkTick1 : unit0Tick);

  // low byte counter; cleared whenever its effective run is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count0_ff <= 8'h00;
    end else if (!runEff0) begin
      count0_ff <= 8'h00;
    end else if (tick0) begin
      count0_ff <= count0_ff + 8'h01;
    end
  end

  // high byte carries from the low byte when cascaded
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count1_ff <= 8'h00;
    end else if (!runEff1) begin
      count1_ff <= 8'h00;
    end else if (ctrl_ff.cascade) begin
      if (tick1 && count0_ff == 8'hff) begin
        count1_ff <= count1_ff + 8'h01;
      end
    end else if (tick1) begin
      count1_ff <= count1_ff + 8'h01;
    end
  end

  // advance strobes for the match, pwm and pulse datapaths outside
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adv0_ff <= 1'b0;
      adv1_ff <= 1'b0;
    end else begin
      adv0_ff <= tick0;
      adv1_ff <= tick1 && !(ctrl_ff.cascade && count0_ff != 8'hff);
    end
  end

  // output pins; unit 0 pins are held high in cascade, as in combine
  dtpc_out_mux u_out_mux (
    .core_clk(core_clk),
    .nrst(nrst),
    .combine(ctrl_ff.outputCombine),
    .cascade(ctrl_ff.cascade),
    .unit0Mode(unit0Mode),
    .unit1Mode(mode1_ff.operatingModeSelect),
    .unit0Running(runEff0),
    .unit1Running(runEff1),
    .unit0Init(unit0OutInit),
    .unit1Init(mode1_ff.outFlipflopInit),
    .unit0PwmWave(unit0PwmWave),
    .unit0PpgWave(unit0PpgWave),
    .unit1PwmWave(unit1PwmWave),
    .unit1PpgWave(unit1PpgWave),
    .pins(pins)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign unit0PulseWidthPin = pins[0];
  assign unit0PatternPin = pins[1];
  assign unit1PulseWidthPin = pins[2];
  assign unit1PatternPin = pins[3];
  assign unit0Advance = adv0_ff;
  assign unit1Advance = adv1_ff;
  assign doubleBufferEnable = mode1_ff.doubleBufferEnable;
  assign operatingModeSelect = mode1_ff.operatingModeSelect;
  assign cascadeMode = ctrl_ff.cascade;
  assign timerPowerEnable = power_ff;

  // steps of a control register write
  sequence seq_ctrl_write;
    wrAccess && hitIdx(paddr, IDX_PAIR_CONTROL) && !stopEntry;
  endsequence

  sequence seq_combine_held;
    ctrl_ff.outputCombine [*2];
  endsequence

  a_mode_lock: assert property (@(posedge core_clk) disable iff (!nrst)
    wrAccess && hitIdx(paddr, IDX_TIMER1_MODE) && ctrl_ff.unit1Run
    |=> $stable(mode1_ff))
    else $error("mode register changed while unit 1 ran");

  a_ctrl_lock: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_ctrl_write ##0 anyRun
    |=> $stable(ctrl_ff.outputCombine) && $stable(ctrl_ff.cascade))
    else $error("combine or cascade changed while running");

  a_start_update: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_ctrl_write ##0 !anyRun
    |=> ctrl_ff.cascade == $past(wrCtrl.cascade) &&
        ctrl_ff.outputCombine == $past(wrCtrl.outputCombine))
    else $error("stopped pair did not take combine or cascade");

  a_stop_clears: assert property (@(posedge core_clk) disable iff (!nrst)
    stopEntry |=> !ctrl_ff.unit1Run && !ctrl_ff.unit0Run ##1 count1_ff == 8'h00)
    else $error("stop state entry left a timer running");

  a_run_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    !runEff0 |=> count0_ff == 8'h00)
    else $error("stopped counter kept its count");

  a_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    psel && penable && !pwrite && hitIdx(paddr, IDX_PAIR_CONTROL)
    |-> prdata[7:4] == 4'h0)
    else $error("control register upper bits read nonzero");

  a_power_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    !pairEn |=> !unit0Advance && !unit1Advance)
    else $error("timer advanced with its power enable off");

  a_cascade_run: assert property (@(posedge core_clk) disable iff (!nrst)
    ctrl_ff.cascade && !ctrl_ff.unit1Run |=> count0_ff == 8'h00)
    else $error("cascaded low byte ran without unit 1 run");

  a_combine_pins: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_combine_held |-> unit0PulseWidthPin && unit0PatternPin)
    else $error("unit 0 pins not high while combined");

  a_power_reset: assert property (@(posedge core_clk)
    $rose(nrst) |-> timerPowerEnable == POWER_ENABLE_RST)
    else $error("power register not cleared by reset");

endmodule
`default_nettype wire
